// >>> hdl/drive_status_map.vh
// Constants for the drive status word and power state machine.
// Assumes inclusion by the drive status modules only.
`ifndef DRIVE_STATUS_MAP_VH
`define DRIVE_STATUS_MAP_VH

// Register word indices on the plain register port
`define REG_CTRL      4'h0
`define REG_STATUS    4'h1
`define REG_MODE      4'h2
`define REG_GCFG      4'h3
`define REG_DSC       4'h4
`define REG_ERR       4'h5

// Reset values
`define CTRL_RST      16'h0000
`define MODE_RST      8'h00
`define GCFG_RST      8'h00
`define DSC_RST       8'h00

// Control word bits
`define CW_SWON       0
`define CW_ENV        1
`define CW_QS         2
`define CW_ENOP       3
`define CW_FRST       7
`define CW_STOP       8
`define CW_RSV_LO     9
`define CW_RSV_HI     10
`define CW_WRST       12

// Status word bits
`define SW_WARN       7
`define SW_RSV8       8
`define SW_REMOTE     9
`define SW_TGT        10
`define SW_ILIM       11
`define SW_RSV12      12
`define SW_LOAD_LO    13
`define SW_LOAD_HI    15

// State-dependent patterns of status bits 0..6
`define SWP_NRDY      7'h00
`define SWP_SOD       7'h40
`define SWP_RDY       7'h21
`define SWP_SWON      7'h33
`define SWP_OPEN      7'h37
`define SWP_QSTOP     7'h17
`define SWP_FREACT    7'h0f
`define SWP_FAULT     7'h08

// Configuration bits
`define GCFG_EXT      0
`define DSC_LOAD      7

// Operating modes, 8-bit two's complement
`define MODE_POS      8'h01
`define MODE_SPEED    8'h02
`define MODE_SETPOS   8'h86
`define MODE_ABS_LO   8'h82
`define MODE_ABS_HI   8'h85
`define MODE_HOME_LO  8'h80
`define MODE_HOME_HI  8'h81

// Error code register values, highest priority first
`define ERR_NONE      8'h00
`define ERR_FAULT     8'h01
`define ERR_OVC       8'h02
`define ERR_UNC       8'h03

`endif

// >>> hdl/rise_detect.v
// Rising edge detector for a group of level bits; rise is combinational.
// Assumes inputs synchronous to clk.
`timescale 1ns/1ps
module rise_detect #(
  parameter WIDTH = 2
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] rise
);
  reg [WIDTH-1:0] level_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n)
          level_r[i] <= 1'b0;
        else
          level_r[i] <= level[i];
      end
      assign rise[i] = level[i] & ~level_r[i];
    end
  endgenerate
endmodule

// >>> hdl/target_reach.v
// Target reached flag, selected by operating mode and stop bit.
// Assumes done and start pulses come from the motion generator.
`timescale 1ns/1ps
`include "drive_status_map.vh"
module target_reach (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [7:0] mode,
  input  wire       stop_eff,
  input  wire       move_start,
  input  wire       pos_done,
  input  wire       speed_hit,
  input  wire       home_done,
  input  wire       set_done,
  input  wire       standstill,
  output reg        target_reached
);
  reg  flag_r;
  reg  flag_nxt;
  reg  done;
  reg  tgt_nxt;
  wire is_abs;
  wire is_home;

  assign is_abs  = (mode == `MODE_POS) ||
                   (mode >= `MODE_ABS_LO && mode <= `MODE_ABS_HI);
  assign is_home = (mode >= `MODE_HOME_LO && mode <= `MODE_HOME_HI);

  always @* begin
    done = 1'b0;
    if (is_abs)
      done = pos_done;
    else if (is_home)
      done = home_done;
    else if (mode == `MODE_SETPOS)
      done = set_done;
    // Done beats start so a zero-length move still ends reached
    flag_nxt = flag_r;
    if (move_start)
      flag_nxt = 1'b0;
    if (done)
      flag_nxt = 1'b1;
    if (stop_eff)
      tgt_nxt = standstill;
    else if (mode == `MODE_SPEED)
      tgt_nxt = speed_hit & ~move_start;
    else
      tgt_nxt = flag_nxt;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r         <= 1'b0;
      target_reached <= 1'b0;
    end else begin
      flag_r         <= flag_nxt;
      target_reached <= tgt_nxt;
    end
  end
endmodule

// >>> hdl/drive_status_word_state_machine.v
// Drive power state machine, status word and control registers.
// Assumes a register master on the plain port and motion, current and
// limit monitors that report synchronous levels and pulses.
`timescale 1ns/1ps
`include "drive_status_map.vh"

module drive_status_word_state_machine (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire        init_done,
  input  wire        ovc_warn,
  input  wire        unc_warn,
  input  wire        fault_event,
  input  wire        fault_react_done,
  input  wire [2:0]  motor_load_level,
  input  wire        limit_upper,
  input  wire        limit_lower,
  input  wire        move_start,
  input  wire        pos_done,
  input  wire        speed_hit,
  input  wire        home_done,
  input  wire        set_done,
  input  wire        standstill,
  output reg  [15:0] drive_status_word,
  output reg  [7:0]  error_code,
  output wire        motion_enable,
  output wire        motor_voltage_on,
  output wire        quick_stop_req
);
  localparam ST_NRDY   = 3'h0;
  localparam ST_SOD    = 3'h1;
  localparam ST_RDY    = 3'h2;
  localparam ST_SWON   = 3'h3;
  localparam ST_OPEN   = 3'h4;
  localparam ST_QSTOP  = 3'h5;
  localparam ST_FREACT = 3'h6;
  localparam ST_FAULT  = 3'h7;

  reg        rst_s1_r;
  reg        rst_n_r;
  wire       rst_n;

  reg [15:0] ctrl_r;
  reg [7:0]  mode_r;
  reg [7:0]  gcfg_r;
  reg [7:0]  dsc_r;
  reg        cmd_r;
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg        ovc_r;
  reg        unc_r;
  reg        fault_r;
  reg [6:0]  pat;
  reg [15:0] sw_nxt;
  reg [7:0]  err_nxt;
  reg [15:0] rdata_nxt;

  wire       ctrl_wr;
  wire [1:0] rst_rise;
  wire       warn_clr;
  wire       fault_clr;
  wire       target_reached;
  wire       stop_eff;
  wire       c_shut;
  wire       c_swon;
  wire       c_dvolt;
  wire       c_qstop;
  wire       c_enop;
  wire       c_ok;

  // Reset released through two flops so the release is glitch free
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end
  assign rst_n = rst_n_r;

  assign ctrl_wr = wr && (addr == `REG_CTRL);

  // Register writes
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `CTRL_RST;
      mode_r <= `MODE_RST;
      gcfg_r <= `GCFG_RST;
      dsc_r  <= `DSC_RST;
      cmd_r  <= 1'b0;
    end else begin
      cmd_r <= ctrl_wr;
      if (ctrl_wr)
        ctrl_r <= wdata;
      if (wr && addr == `REG_MODE)
        mode_r <= wdata[7:0];
      if (wr && addr == `REG_GCFG)
        gcfg_r <= wdata[7:0];
      if (wr && addr == `REG_DSC)
        dsc_r <= wdata[7:0];
    end
  end

  // Edges of fault reset and warning reset
  rise_detect #(
    .WIDTH (2)
  ) u_rise (
    .clk   (clk_sys),
    .rst_n (rst_n),
    .level ({ctrl_r[`CW_WRST], ctrl_r[`CW_FRST]}),
    .rise  (rst_rise)
  );
  assign fault_clr = rst_rise[0];
  assign warn_clr  = rst_rise[1] | rst_rise[0];

  // Command decode, evaluated once per control word write
  assign c_ok    = cmd_r & ~ctrl_r[`CW_FRST] &
                   ~ctrl_r[`CW_RSV_LO] & ~ctrl_r[`CW_RSV_HI];
  assign c_shut  = c_ok & ctrl_r[`CW_QS] & ctrl_r[`CW_ENV] &
                   ~ctrl_r[`CW_SWON];
  assign c_swon  = c_ok & ~ctrl_r[`CW_ENOP] & ctrl_r[`CW_QS] &
                   ctrl_r[`CW_ENV] & ctrl_r[`CW_SWON];
  assign c_enop  = c_ok & ctrl_r[`CW_ENOP] & ctrl_r[`CW_QS] &
                   ctrl_r[`CW_ENV] & ctrl_r[`CW_SWON];
  assign c_dvolt = c_ok & ~ctrl_r[`CW_ENV];
  assign c_qstop = c_ok & ctrl_r[`CW_ENV] & ~ctrl_r[`CW_QS];

  // Power state machine
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_NRDY: begin
        if (init_done)
          state_nxt = ST_SOD;
      end
      ST_SOD: begin
        if (c_shut)
          state_nxt = ST_RDY;
      end
      ST_RDY: begin
        if (c_swon)
          state_nxt = ST_SWON;
        else if (c_dvolt || c_qstop)
          state_nxt = ST_SOD;
      end
      ST_SWON: begin
        if (c_enop)
          state_nxt = ST_OPEN;
        else if (c_shut)
          state_nxt = ST_RDY;
        else if (c_dvolt || c_qstop)
          state_nxt = ST_SOD;
      end
      ST_OPEN: begin
        if (c_swon)
          state_nxt = ST_SWON;
        else if (c_shut)
          state_nxt = ST_RDY;
        else if (c_qstop)
          state_nxt = ST_QSTOP;
        else if (c_dvolt)
          state_nxt = ST_SOD;
      end
      ST_QSTOP: begin
        if (c_enop)
          state_nxt = ST_OPEN;
        else if (c_dvolt)
          state_nxt = ST_SOD;
      end
      ST_FREACT: begin
        if (fault_react_done)
          state_nxt = ST_FAULT;
      end
      ST_FAULT: begin
        if (fault_clr)
          state_nxt = ST_SOD;
      end
      default: state_nxt = ST_NRDY;
    endcase
    // A fault overrides any command from switch-on disabled through quick stop
    if (fault_event && state_r != ST_NRDY &&
        state_r != ST_FREACT && state_r != ST_FAULT)
      state_nxt = ST_FREACT;
  end

  // Reset lands in not-ready with no command needed
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      state_r <= ST_NRDY;
    else
      state_r <= state_nxt;
  end

  assign motion_enable    = (state_r == ST_OPEN);
  assign quick_stop_req   = (state_r == ST_QSTOP);
  assign motor_voltage_on = (state_r == ST_SWON) ||
                            (state_r == ST_OPEN) ||
                            (state_r == ST_QSTOP);

  // Sticky warnings and error; a new event beats a clear
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovc_r   <= 1'b0;
      unc_r   <= 1'b0;
      fault_r <= 1'b0;
    end else begin
      ovc_r   <= ovc_warn | (ovc_r & ~warn_clr);
      unc_r   <= unc_warn | (unc_r & ~warn_clr);
      fault_r <= fault_event | (fault_r & ~fault_clr);
    end
  end

  // Stop bit only counts with the extended control word enabled
  assign stop_eff = gcfg_r[`GCFG_EXT] & ctrl_r[`CW_STOP];

  target_reach u_tgt (
    .clk            (clk_sys),
    .rst_n          (rst_n),
    .mode           (mode_r),
    .stop_eff       (stop_eff),
    .move_start     (move_start),
    .pos_done       (pos_done),
    .speed_hit      (speed_hit),
    .home_done      (home_done),
    .set_done       (set_done),
    .standstill     (standstill),
    .target_reached (target_reached)
  );

  // Status word assembly
  always @* begin
    case (state_r)
      ST_NRDY:   pat = `SWP_NRDY;
      ST_SOD:    pat = `SWP_SOD;
      ST_RDY:    pat = `SWP_RDY;
      ST_SWON:   pat = `SWP_SWON;
      ST_OPEN:   pat = `SWP_OPEN;
      ST_QSTOP:  pat = `SWP_QSTOP;
      ST_FREACT: pat = `SWP_FREACT;
      ST_FAULT:  pat = `SWP_FAULT;
      default:   pat = `SWP_NRDY;
    endcase
    // Don't-care positions of the patterns are already 0
    sw_nxt = 16'h0000;
    sw_nxt[6:0]          = pat;
    sw_nxt[`SW_WARN]     = ovc_r | unc_r;
    sw_nxt[`SW_RSV8]     = 1'b0;
    sw_nxt[`SW_REMOTE]   = 1'b1;
    sw_nxt[`SW_TGT]      = target_reached;
    sw_nxt[`SW_ILIM]     = limit_upper | limit_lower;
    sw_nxt[`SW_RSV12]    = 1'b0;
    if (dsc_r[`DSC_LOAD])
      sw_nxt[`SW_LOAD_HI:`SW_LOAD_LO] = motor_load_level;
  end

  // Error code: highest priority pending item
  always @* begin
    if (fault_r)
      err_nxt = `ERR_FAULT;
    else if (ovc_r)
      err_nxt = `ERR_OVC;
    else if (unc_r)
      err_nxt = `ERR_UNC;
    else
      err_nxt = `ERR_NONE;
  end

  // Read mux; unmapped addresses read 0
  always @* begin
    case (addr)
      `REG_CTRL:   rdata_nxt = ctrl_r;
      `REG_STATUS: rdata_nxt = drive_status_word;
      `REG_MODE:   rdata_nxt = {8'h00, mode_r};
      `REG_GCFG:   rdata_nxt = {8'h00, gcfg_r};
      `REG_DSC:    rdata_nxt = {8'h00, dsc_r};
      `REG_ERR:    rdata_nxt = {8'h00, error_code};
      default:     rdata_nxt = 16'h0000;
    endcase
  end

  // Status is one cycle behind its sources; read data only after rd
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      drive_status_word <= 16'h0000;
      error_code        <= `ERR_NONE;
      rdata             <= 16'h0000;
    end else begin
      drive_status_word <= sw_nxt;
      error_code        <= err_nxt;
      if (rd)
        rdata <= rdata_nxt;
      else
        rdata <= 16'h0000;
    end
  end
endmodule

// >>> sim/drive_status_chk.sv
// Checker for the drive status word and power state machine.
// Sees only the top module ports; bound from the testbench top.
`timescale 1ns/1ps
`include "drive_status_map.vh"
module drive_status_chk (
  input wire        clk_sys,
  input wire        nrst,
  input wire [3:0]  addr,
  input wire [15:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [15:0] rdata,
  input wire        init_done,
  input wire        ovc_warn,
  input wire        unc_warn,
  input wire        fault_event,
  input wire [2:0]  motor_load_level,
  input wire        limit_upper,
  input wire        limit_lower,
  input wire [15:0] drive_status_word,
  input wire        motion_enable,
  input wire        motor_voltage_on,
  input wire        quick_stop_req
);
  reg        r1_r;
  reg        r2_r;
  reg        ok_r;
  reg        ld_r;
  wire [6:0] sp;
  assign sp = drive_status_word[6:0];
  // Mirror the two-flop release plus one edge for the first status load
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r1_r <= 1'b0;
      r2_r <= 1'b0;
      ok_r <= 1'b0;
      ld_r <= 1'b0;
    end else begin
      r1_r <= 1'b1;
      r2_r <= r1_r;
      ok_r <= r2_r;
      if (wr && addr == `REG_DSC)
        ld_r <= wdata[`DSC_LOAD];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!ok_r);
  fixed_bits_a: assert property (
    drive_status_word[9] && !drive_status_word[8] && !drive_status_word[12])
    else $error("fixed status bits wrong");
  state_code_a: assert property (
    sp inside {`SWP_NRDY, `SWP_SOD, `SWP_RDY, `SWP_SWON, `SWP_OPEN,
               `SWP_QSTOP, `SWP_FREACT, `SWP_FAULT})
    else $error("illegal state pattern");
  load_gate_a: assert property (
    drive_status_word[15:13] ==
      ($past(ld_r) ? $past(motor_load_level) : 3'h0))
    else $error("load field wrong");
  int_limit_a: assert property (
    drive_status_word[11] == $past(limit_upper || limit_lower))
    else $error("limit bit wrong");
  motion_gate_a: assert property (
    $past(motion_enable) == (sp == `SWP_OPEN))
    else $error("motion enable outside enabled state");
  voltage_bit_a: assert property (
    $past(motor_voltage_on) == drive_status_word[4]
    && $past(quick_stop_req) == (sp == `SWP_QSTOP))
    else $error("voltage or quick stop mismatch");
  warn_set_a: assert property (
    (ovc_warn || unc_warn) |-> ##[1:2] drive_status_word[7])
    else $error("warning bit not set");
  fault_entry_a: assert property (
    fault_event |-> ##[1:3] drive_status_word[3])
    else $error("fault bit not set");
  init_move_a: assert property (
    (sp == `SWP_NRDY && init_done) |-> ##[1:3] sp == `SWP_SOD)
    else $error("init did not leave not ready");
  shutdown_cmd_a: assert property (
    (wr && addr == `REG_CTRL && wdata == 16'h0006 && sp == `SWP_SOD
     && !fault_event) |-> ##3 sp == `SWP_RDY)
    else $error("shutdown not taken");
  read_back_a: assert property (
    (rd && addr == `REG_STATUS) |=> rdata == $past(drive_status_word))
    else $error("status read wrong");
  read_idle_a: assert property (
    !rd |=> rdata == 16'h0000)
    else $error("read data not zero");
  cover property (sp == `SWP_OPEN);
  cover property (sp == `SWP_FAULT);
  cover property (drive_status_word[15:13] != 3'h0);
endmodule

// >>> sim/ctrl_app_model.sv
// Controlling application: masters the plain register port.
// Assumes one clock; tasks are called from the testbench top.
`timescale 1ns/1ps
module ctrl_app_model (
  input  wire        clk_sys,
  output reg  [3:0]  addr,
  output reg  [15:0] wdata,
  output reg         wr,
  output reg         rd,
  input  wire [15:0] rdata
);
  initial begin
    addr = 4'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // Every register write, control word or other, is a one-cycle strobe
  task wreg(input [3:0] a, input [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    // Bus left inverted so a stale value is never mistaken for data
    wdata <= ~d;
  endtask
  // Data taken in the single cycle after the strobe
  task rreg(input [3:0] a, output [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    // Mid-cycle sample keeps clear of the edge that updates rdata
    @(negedge clk_sys);
    d = rdata;
  endtask
endmodule

// >>> sim/drive_status_word_state_machine_tb_top.sv
// Testbench top for the drive status word and power state machine.
// Assumes the application model and the checker bound below.
`timescale 1ns/1ps
`include "drive_status_map.vh"
module drive_status_word_state_machine_tb_top;
  reg         clk_sys = 1'b0;
  reg         nrst = 1'b0;
  reg         init_done = 1'b0;
  reg         ovc_warn = 1'b0;
  reg         unc_warn = 1'b0;
  reg         fault_event = 1'b0;
  reg         fault_react_done = 1'b0;
  reg  [2:0]  motor_load_level = 3'h0;
  reg         limit_upper = 1'b0;
  reg         limit_lower = 1'b0;
  reg         move_start = 1'b0;
  reg  [2:0]  dn = 3'h0;
  reg         speed_hit = 1'b0;
  reg         standstill = 1'b0;
  wire [3:0]  addr;
  wire [15:0] wdata;
  wire        wr;
  wire        rd;
  wire [15:0] rdata;
  wire [15:0] sw;
  wire [7:0]  error_code;
  wire        motion_enable;
  wire        motor_voltage_on;
  wire        quick_stop_req;
  reg  [15:0] d;
  integer     num_errors = 0;
  integer     n_checks = 0;
  integer     i;
  always #5 clk_sys = ~clk_sys;
  ctrl_app_model app_u (.clk_sys(clk_sys), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  drive_status_word_state_machine dut_u (.clk_sys(clk_sys), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .init_done(init_done), .ovc_warn(ovc_warn), .unc_warn(unc_warn),
    .fault_event(fault_event), .fault_react_done(fault_react_done),
    .motor_load_level(motor_load_level), .limit_upper(limit_upper),
    .limit_lower(limit_lower), .move_start(move_start),
    .pos_done(dn[0]), .speed_hit(speed_hit), .home_done(dn[1]),
    .set_done(dn[2]), .standstill(standstill),
    .drive_status_word(sw), .error_code(error_code),
    .motion_enable(motion_enable), .motor_voltage_on(motor_voltage_on),
    .quick_stop_req(quick_stop_req));
  task summarize;
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input [15:0] e, input [15:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      num_errors = num_errors + 1;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Fixed bits, warning bit and state pattern; monitor fields masked
  task st(input [15:0] g, input [6:0] p, input w);
    chk("status", 16'h0200 | {8'h00, w, p}, g & 16'h13ff);
  endtask
  task tgt(input e);
    wt(3);
    chk("target", {15'h0000, e}, {15'h0000, sw[`SW_TGT]});
  endtask
  task pulse_tg(input [7:0] m, input integer k);
    app_u.wreg(`REG_MODE, {8'h00, m});
    @(posedge clk_sys) move_start <= 1'b1;
    @(posedge clk_sys) move_start <= 1'b0;
    tgt(1'b0);
    dn <= 3'h1 << k;
    @(posedge clk_sys) dn <= 3'h0;
    tgt(1'b1);
  endtask
  initial begin
    wt(5);
    nrst <= 1'b1;
    wt(4);
    st(sw, `SWP_NRDY, 1'b0);
    init_done <= 1'b1;
    wt(4);
    app_u.rreg(`REG_STATUS, d);
    st(d, `SWP_SOD, 1'b0);
    app_u.rreg(4'hf, d);
    chk("unmapped", 16'h0000, d);
    app_u.wreg(`REG_STATUS, 16'hffff);
    for (i = 0; i < 3; i = i + 1) begin
      app_u.wreg(`REG_CTRL, i == 0 ? 16'h0006 : i == 1 ? 16'h0007 : 16'h000f);
      wt(4);
      st(sw, i == 0 ? `SWP_RDY : i == 1 ? `SWP_SWON : `SWP_OPEN,
         1'b0);
    end
    chk("motion", 16'h0001, {15'h0000, motion_enable});
    @(posedge clk_sys) ovc_warn <= 1'b1;
    @(posedge clk_sys) ovc_warn <= 1'b0;
    wt(3);
    st(sw, `SWP_OPEN, 1'b1);
    chk("error", 16'h0002, {8'h00, error_code});
    app_u.wreg(`REG_CTRL, 16'h100f);
    wt(4);
    st(sw, `SWP_OPEN, 1'b0);
    app_u.wreg(`REG_CTRL, 16'h000f);
    @(posedge clk_sys) unc_warn <= 1'b1;
    @(posedge clk_sys) unc_warn <= 1'b0;
    wt(3);
    chk("error", 16'h0003, {8'h00, error_code});
    motor_load_level <= 3'h5;
    limit_lower <= 1'b1;
    wt(3);
    chk("load", 16'h0800, sw & 16'he800);
    app_u.wreg(`REG_DSC, 16'h0080);
    limit_lower <= 1'b0;
    wt(3);
    chk("load", 16'ha000, sw & 16'he800);
    app_u.wreg(`REG_MODE, {8'h00, `MODE_SPEED});
    tgt(1'b0);
    speed_hit <= 1'b1;
    tgt(1'b1);
    speed_hit <= 1'b0;
    pulse_tg(`MODE_POS, 0);
    pulse_tg(`MODE_ABS_LO, 0);
    pulse_tg(`MODE_ABS_HI, 0);
    pulse_tg(`MODE_HOME_LO, 1);
    pulse_tg(`MODE_HOME_HI, 1);
    pulse_tg(`MODE_SETPOS, 2);
    app_u.wreg(`REG_CTRL, 16'h010f);
    tgt(1'b1);
    app_u.wreg(`REG_GCFG, 16'h0001);
    tgt(1'b0);
    standstill <= 1'b1;
    tgt(1'b1);
    app_u.wreg(`REG_CTRL, 16'h000b);
    wt(4);
    st(sw, `SWP_QSTOP, 1'b1);
    chk("qstop", 16'h0001, {15'h0000, quick_stop_req});
    @(posedge clk_sys) fault_event <= 1'b1;
    @(posedge clk_sys) fault_event <= 1'b0;
    wt(3);
    st(sw, `SWP_FREACT, 1'b1);
    chk("error", 16'h0001, {8'h00, error_code});
    @(posedge clk_sys) fault_react_done <= 1'b1;
    @(posedge clk_sys) fault_react_done <= 1'b0;
    wt(3);
    st(sw, `SWP_FAULT, 1'b1);
    app_u.wreg(`REG_CTRL, 16'h0080);
    wt(4);
    st(sw, `SWP_SOD, 1'b0);
    chk("error", 16'h0000, {8'h00, error_code});
    summarize;
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #100000;
    num_errors = num_errors + 1;
    summarize;
  end
endmodule
bind drive_status_word_state_machine drive_status_chk chk_u (
  .clk_sys(clk_sys), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .init_done(init_done), .ovc_warn(ovc_warn),
  .unc_warn(unc_warn), .fault_event(fault_event),
  .motor_load_level(motor_load_level), .limit_upper(limit_upper),
  .limit_lower(limit_lower), .drive_status_word(drive_status_word),
  .motion_enable(motion_enable), .motor_voltage_on(motor_voltage_on),
  .quick_stop_req(quick_stop_req));
